/* File: rtl/asr_buf.sv */
// Small valid/ready buffer held in flip-flops
`timescale 1ns/1ps
module asr_buf #(
    parameter int W = 7,
    parameter int DEPTH = 2
) (
    // Clock, reset and enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_en,
    // Fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    // Drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    wire push = i_valid && o_ready;
    wire pop = o_valid && i_ready;
    wire [PW-1:0] wr_nxt = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    wire [PW-1:0] rd_nxt = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;

    // Full is honest: a stalled drain side really fills it
    assign o_ready = (cnt_q != CW'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign o_data = mem_q[rd_q];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (i_en) begin
            if (push) wr_q <= wr_nxt;
            if (pop) rd_q <= rd_nxt;
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_en && push) mem_q[wr_q] <= i_data;
    end

endmodule // asr_buf

/* File: rtl/asr_cfg.svh */
// Constants of the addressable serial responder
// Operation
// - Receive bit clock starts on a start bit, running at clock divided by 64.
// - Every received bit is sampled at the middle of its bit period.
// - Eight data bits follow start; seven compare with the station address pins.
// - Station address is latched 31 clocks after the address start bit ends.
// - Eighth data bit is the word type: 1 address, 0 command.
// - A parity bit checked for even parity follows, then one stop bit.
// - A good address word matching the station address pulses the match output.
// - Command word follows the address word with identical framing and type 0.
// - The command strobe marks valid command outputs at the end of a command.
// - The command strobe pulse lasts exactly one clock cycle.
// - A rising edge on send starts the transmit sequence.
// - Two eleven-bit words go out, carrying first byte then second byte.
// - First byte is captured one clock before the first start bit begins.
// - Second byte is captured at the end of the first start bit.
// - The transmit output is inverted against the receive line polarity.
// - Transmission begins between one half and one and a half bits after send.
// - Reset held low at least 700 ns leaves the device ready.
// - Command outputs carry the seven command bits of the second word.
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH

`define ASR_CLK_PERIOD_NS 25
`define ASR_RST_MIN_NS 700
`define ASR_RST_MIN_CYC ((`ASR_RST_MIN_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)

`define ASR_DIV_ZERO 6'h00
`define ASR_DIV_LAST 6'h3f
`define ASR_HALF 6'h20
`define ASR_ADDR_LATCH 6'h1f

`define ASR_RX_START 4'h0
`define ASR_RX_FIRST 4'h1
`define ASR_RX_STOP 4'ha

`define ASR_TX_START 5'h00
`define ASR_TX_W1_STOP 5'h0a
`define ASR_TX_LAST 5'h15

`endif

/* File: rtl/asr_pkg.sv */
// Types of the addressable serial responder
package asr_pkg;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic rx;
        logic send;
    } asr_pins_type;

    typedef struct packed {
        logic [6:0] cmd;
    } asr_cmd_type;

    typedef enum logic {RX_IDLE, RX_BUSY} asr_rx_state_type;

    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} asr_tx_state_type;

endpackage

/* File: rtl/asr_top.sv */
// Addressable serial responder: receiver, command buffer and transmitter
`timescale 1ns/1ps
`include "asr_cfg.svh"
module asr_top
    import asr_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // Serial line
    input wire logic i_serial_rx_in,
    output logic o_serial_tx_out_n,
    // Station address and transmit data pins
    input wire logic [6:0] i_station_addr_in,
    input wire logic [7:0] i_first_tx_byte_in,
    input wire logic [7:0] i_second_tx_byte_in,
    input wire logic i_send,
    // Receive results
    output logic o_address_match_pulse,
    output logic [6:0] o_command_bits_out,
    output logic o_command_strobe,
    input wire logic i_cmd_ready,
    output logic o_cmd_overrun
);

    // --------------------
    // Reset release
    // --------------------
    logic [1:0] rst_sync_q;
    wire rst_n = rst_sync_q[1];

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // --------------------
    // Pin synchronisers
    // --------------------
    asr_pins_type pins_raw;
    asr_pins_type pins_s1_q;
    asr_pins_type pins_q;

    assign pins_raw = {i_station_addr_in, i_first_tx_byte_in,
                       i_second_tx_byte_in, i_serial_rx_in, i_send};

    // Reset to all ones: idle line, and no send edge right after reset
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_s1_q <= '1;
            pins_q <= '1;
        end else if (i_clk_en) begin
            pins_s1_q <= pins_raw;
            pins_q <= pins_s1_q;
        end
    end

    logic rx_prev_q;
    logic send_prev_q;

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_prev_q <= 1'b1;
            send_prev_q <= 1'b1;
        end else if (i_clk_en) begin
            rx_prev_q <= pins_q.rx;
            send_prev_q <= pins_q.send;
        end
    end

    // --------------------
    // Receiver
    // --------------------
    asr_rx_state_type rx_state_q;
    logic [5:0] rx_div_q;
    logic [3:0] rx_bit_q;
    logic [8:0] rx_sh_q;
    logic [6:0] addr_q;
    logic expect_q;

    wire rx_busy = (rx_state_q == RX_BUSY);
    wire rx_start = !rx_busy && rx_prev_q && !pins_q.rx;
    wire rx_sample = rx_busy && (rx_div_q == `ASR_HALF);
    wire rx_false = rx_sample && (rx_bit_q == `ASR_RX_START) && pins_q.rx;
    wire rx_data = rx_sample && (rx_bit_q != `ASR_RX_START) && (rx_bit_q != `ASR_RX_STOP);
    wire rx_end = rx_sample && (rx_bit_q == `ASR_RX_STOP);
    wire addr_latch = rx_busy && (rx_bit_q == `ASR_RX_FIRST) && (rx_div_q == `ASR_ADDR_LATCH);

    // Word decode at the stop bit
    wire par_ok = ~^rx_sh_q;
    wire word_ok = rx_end && pins_q.rx && par_ok;
    wire is_addr = rx_sh_q[7];
    wire [6:0] rx_val = rx_sh_q[6:0];
    wire match_d = word_ok && is_addr && (rx_val == addr_q);
    wire cmd_push = word_ok && !is_addr && expect_q;

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_q <= RX_IDLE;
        end else if (i_clk_en) begin
            if (rx_start) rx_state_q <= RX_BUSY;
            else if (rx_false || rx_end) rx_state_q <= RX_IDLE;
        end
    end

    // Bit clock restarts on every start bit, so words may follow closely
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_div_q <= `ASR_DIV_ZERO;
            rx_bit_q <= `ASR_RX_START;
        end else if (i_clk_en) begin
            if (rx_start) begin
                rx_div_q <= `ASR_DIV_ZERO;
                rx_bit_q <= `ASR_RX_START;
            end else if (rx_busy) begin
                rx_div_q <= rx_div_q + 6'h01;
                if (rx_div_q == `ASR_DIV_LAST) rx_bit_q <= rx_bit_q + 4'h1;
            end
        end
    end

    // Data bits arrive low bit first, parity last
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh_q <= '0;
        end else if (i_clk_en && rx_data) begin
            rx_sh_q <= {pins_q.rx, rx_sh_q[8:1]};
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
        end else if (i_clk_en && addr_latch) begin
            addr_q <= pins_q.addr;
        end
    end

    // Only the word right after a matching address may be a command
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            expect_q <= 1'b0;
        end else if (i_clk_en && rx_end) begin
            expect_q <= match_d;
        end
    end

    logic match_q;
    assign o_address_match_pulse = match_q;

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_q <= 1'b0;
        end else if (i_clk_en) begin
            match_q <= match_d;
        end
    end

    // --------------------
    // Command buffer
    // --------------------
    asr_cmd_type cmd_in;
    asr_cmd_type cmd_out;
    logic buf_in_ready;
    logic buf_out_valid;
    logic strobe_gap_q;
    logic overrun_q;

    assign cmd_in.cmd = rx_val;
    wire cmd_accept = cmd_push && buf_in_ready;

    // Gap cycle keeps each strobe a single cycle even when words queue
    assign o_command_strobe = buf_out_valid && i_cmd_ready && !strobe_gap_q && i_clk_en;
    assign o_command_bits_out = cmd_out.cmd;
    assign o_cmd_overrun = overrun_q;

    asr_buf #(
        .W($bits(asr_cmd_type)),
        .DEPTH(BUF_DEPTH)
    ) u_cmd_buf (
        .i_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .i_en(i_clk_en),
        .i_valid(cmd_accept),
        .o_ready(buf_in_ready),
        .i_data(cmd_in),
        .o_valid(buf_out_valid),
        .i_ready(o_command_strobe),
        .o_data(cmd_out)
    );

    // Serial line cannot be stalled; a full buffer drops the word and flags it
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_gap_q <= 1'b0;
            overrun_q <= 1'b0;
        end else if (i_clk_en) begin
            strobe_gap_q <= o_command_strobe;
            overrun_q <= cmd_push && !buf_in_ready;
        end
    end

    // --------------------
    // Transmitter
    // --------------------
    asr_tx_state_type tx_state_q;
    logic [5:0] tx_div_q;
    logic [4:0] tx_bit_q;
    logic [10:0] tx_sh_q;
    logic [7:0] byte2_q;
    logic skip_q;
    logic tx_out_q;

    // Frame low bit first: start 0, data, even parity, stop 1
    function automatic logic [10:0] mk_frame(input logic [7:0] b);
        mk_frame = {1'b1, ^b, b, 1'b0};
    endfunction

    wire tx_wrap = (tx_div_q == `ASR_DIV_LAST);
    wire send_rise = (tx_state_q == TX_IDLE) && pins_q.send && !send_prev_q;
    wire skip_d = (tx_div_q > `ASR_HALF) && !tx_wrap;
    wire tx_load = (tx_state_q == TX_WAIT) && tx_wrap && !skip_q;
    wire tx_step = (tx_state_q == TX_SHIFT) && tx_wrap;
    wire tx_done = tx_step && (tx_bit_q == `ASR_TX_LAST);
    wire tx_word2 = tx_step && (tx_bit_q == `ASR_TX_W1_STOP);
    wire tx_grab2 = tx_step && (tx_bit_q == `ASR_TX_START);

    // Free running bit clock; its phase at send decides the start delay
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_div_q <= `ASR_DIV_ZERO;
        end else if (i_clk_en) begin
            tx_div_q <= tx_div_q + 6'h01;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_q <= TX_IDLE;
            skip_q <= 1'b0;
        end else if (i_clk_en) begin
            unique case (tx_state_q)
                TX_IDLE: begin
                    if (send_rise) begin
                        tx_state_q <= TX_WAIT;
                        skip_q <= skip_d;
                    end
                end
                TX_WAIT: begin
                    if (tx_wrap) skip_q <= 1'b0;
                    if (tx_load) tx_state_q <= TX_SHIFT;
                end
                TX_SHIFT: begin
                    if (tx_done) tx_state_q <= TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_bit_q <= `ASR_TX_START;
        end else if (i_clk_en) begin
            if (tx_load) tx_bit_q <= `ASR_TX_START;
            else if (tx_step) tx_bit_q <= tx_bit_q + 5'h01;
        end
    end

    // Line level is inverted: idle drives low, start bit drives high
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh_q <= '0;
            tx_out_q <= 1'b0;
        end else if (i_clk_en) begin
            if (tx_load) begin
                tx_sh_q <= mk_frame(pins_q.byte1);
                tx_out_q <= 1'b1;
            end else if (tx_done) begin
                tx_out_q <= 1'b0;
            end else if (tx_word2) begin
                tx_sh_q <= mk_frame(byte2_q);
                tx_out_q <= 1'b1;
            end else if (tx_step) begin
                tx_sh_q <= {1'b0, tx_sh_q[10:1]};
                tx_out_q <= ~tx_sh_q[1];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            byte2_q <= '0;
        end else if (i_clk_en && tx_grab2) begin
            byte2_q <= pins_q.byte2;
        end
    end

    assign o_serial_tx_out_n = tx_out_q;

    // --------------------
    // Assertions
    // --------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking

    default disable iff (!rst_n || !i_clk_en);

    property p_rx_clock_start;
        rx_start |=> rx_busy && (rx_div_q == `ASR_DIV_ZERO);
    endproperty
    a_rx_clock_start: assert property (p_rx_clock_start)
        else $error("receive bit clock did not start");

    property p_mid_sample;
        rx_start ##1 !pins_q.rx [*8] |-> ##25 rx_sample;
    endproperty
    a_mid_sample: assert property (p_mid_sample)
        else $error("start bit not sampled at mid bit");

    property p_addr_latch;
        addr_latch |=> addr_q == $past(pins_q.addr);
    endproperty
    a_addr_latch: assert property (p_addr_latch)
        else $error("station address not latched");

    property p_match;
        match_d |=> o_address_match_pulse ##1 !o_address_match_pulse;
    endproperty
    a_match: assert property (p_match)
        else $error("address match pulse wrong");

    property p_parity;
        rx_end && !par_ok |=> !o_address_match_pulse;
    endproperty
    a_parity: assert property (p_parity)
        else $error("bad parity word accepted");

    property p_cmd_gate;
        cmd_accept |-> expect_q && !is_addr;
    endproperty
    a_cmd_gate: assert property (p_cmd_gate)
        else $error("command taken without matching address");

    property p_strobe_width;
        o_command_strobe |=> !o_command_strobe;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("command strobe longer than one cycle");

    property p_send_start;
        send_rise |=> tx_state_q == TX_WAIT;
    endproperty
    a_send_start: assert property (p_send_start)
        else $error("send edge ignored");

    property p_start_delay;
        send_rise |-> ##[31:94] tx_load;
    endproperty
    a_start_delay: assert property (p_start_delay)
        else $error("transmit start delay out of range");

    property p_first_byte;
        tx_load |=> o_serial_tx_out_n && (tx_sh_q[8:1] == $past(pins_q.byte1));
    endproperty
    a_first_byte: assert property (p_first_byte)
        else $error("first byte not captured before start bit");

    property p_idle_low;
        tx_state_q == TX_IDLE && $past(tx_state_q) == TX_IDLE |-> !o_serial_tx_out_n;
    endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("inverted idle level wrong");

    c_match: cover property (o_address_match_pulse);
    c_strobe: cover property (o_command_strobe);
    c_tx_done: cover property (tx_done);
    c_overrun: cover property (o_cmd_overrun);

endmodule // asr_top

/* File: testbench/asr_master_model.sv */
// Behavioural model of the master controller on the serial line
`timescale 1ns/1ps
module asr_master_model (
    // Clock
    input wire logic i_ref_clk,
    // Serial line
    input wire logic i_tx_n,
    output logic o_rx
);
    // ----------------------------------------
    // Line idles high between words
    // ----------------------------------------
    initial o_rx = 1'b1;

    // One framed word, LSB first; bad_par flips parity on purpose
    task automatic send_word(input logic [7:0] data, input logic bad_par);
        logic [10:0] frame;
        frame = {1'b1, (^data) ^ bad_par, data, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(negedge i_ref_clk);
            o_rx = frame[i];
            repeat (63) @(negedge i_ref_clk);
        end
    endtask

    // Waits for an inverted start bit, then samples each bit at its middle
    task automatic recv_word(input int max_wait, output logic [7:0] data, output logic frame_ok,
                             output int waited);
        logic [10:0] bits;
        waited = 0;
        while (i_tx_n !== 1'b1 && waited < max_wait) begin
            @(posedge i_ref_clk);
            waited++;
        end
        repeat (32) @(posedge i_ref_clk);
        for (int i = 0; i < 11; i++) begin
            bits[i] = ~i_tx_n;
            if (i < 10) repeat (64) @(posedge i_ref_clk);
        end
        data = bits[8:1];
        frame_ok = (bits[0] === 1'b0) && (bits[10] === 1'b1) && ((^bits[9:1]) === 1'b0);
    endtask
endmodule // asr_master_model

/* File: testbench/asr_top_test.sv */
// Self-checking testbench of the addressable serial responder
`timescale 1ns/1ps
module asr_top_test;
    localparam logic [6:0] STATION = 7'h5a;

    logic clk, rst_n, clk_en, rx, tx_n, send, match, strobe, cmd_ready, overrun;
    logic [6:0] station, cmd;
    logic [7:0] byte1, byte2;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_match = 0;
    int n_strobe = 0;
    int n_overrun = 0;
    logic [6:0] cmd_q[$];

    asr_top #(.BUF_DEPTH(2)) asr_top_i (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
        .i_serial_rx_in(rx), .o_serial_tx_out_n(tx_n),
        .i_station_addr_in(station), .i_first_tx_byte_in(byte1), .i_second_tx_byte_in(byte2),
        .i_send(send), .o_address_match_pulse(match), .o_command_bits_out(cmd),
        .o_command_strobe(strobe), .i_cmd_ready(cmd_ready), .o_cmd_overrun(overrun)
    );
    asr_master_model asr_master_model_i (.i_ref_clk(clk), .i_tx_n(tx_n), .o_rx(rx));

    // ----------------------------------------
    // Clock, monitor, compare tasks
    // ----------------------------------------
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // Pulses last one cycle, so they are counted at every edge
    always @(posedge clk) begin
        if (match === 1'b1) n_match++;
        if (overrun === 1'b1) n_overrun++;
        if (strobe === 1'b1) begin
            n_strobe++;
            cmd_q.push_back(cmd);
        end
    end

    task automatic check_bits(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic check_count(input string name, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
        end
    endtask

    function automatic logic [7:0] pop_cmd();
        return (cmd_q.size() > 0) ? {1'b0, cmd_q.pop_front()} : 8'hxx;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Address word then command word, back to back
    task automatic send_pair(input logic [6:0] addr, input logic [6:0] c, input logic bad_par);
        asr_master_model_i.send_word({1'b1, addr}, bad_par);
        asr_master_model_i.send_word({1'b0, c}, 1'b0);
        repeat (8) @(negedge clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_match_command();
        int m0, s0;
        m0 = n_match;
        s0 = n_strobe;
        cmd_q.delete();
        // Command equals the station address: a decoder blind to the type bit pulses match twice
        send_pair(STATION, STATION, 1'b0);
        check_count("match pulses", m0 + 1, n_match);
        check_count("strobes", s0 + 1, n_strobe);
        check_bits("command", {1'b0, STATION}, pop_cmd());
    endtask

    // Each address bit flipped in turn; the following command must be dropped
    task automatic t_mismatch();
        int m0, s0;
        m0 = n_match;
        s0 = n_strobe;
        for (int i = 0; i < 7; i++) send_pair(STATION ^ (7'h01 << i), 7'h2b, 1'b0);
        check_count("match pulses on foreign address", m0, n_match);
        check_count("strobes after foreign address", s0, n_strobe);
    endtask

    task automatic t_bad_parity();
        int m0, s0;
        m0 = n_match;
        s0 = n_strobe;
        send_pair(STATION, 7'h22, 1'b1);
        check_count("match pulses on bad parity", m0, n_match);
        check_count("strobes after bad parity", s0, n_strobe);
    endtask

    // Byte pins change as the first start bit appears: first word keeps the old byte, second takes the new
    task automatic t_transmit();
        logic [7:0] d1, d2;
        logic ok1, ok2;
        int w1, w2;
        check_bits("idle line", 8'h00, {7'h00, tx_n});
        byte1 = 8'hc3;
        byte2 = 8'h5e;
        @(negedge clk);
        send = 1'b1;
        fork
            begin
                asr_master_model_i.recv_word(200, d1, ok1, w1);
                asr_master_model_i.recv_word(200, d2, ok2, w2);
            end
            begin
                for (int k = 0; k < 200 && tx_n !== 1'b1; k++) @(posedge clk);
                @(negedge clk);
                byte1 = 8'h3c;
                byte2 = 8'h81;
            end
        join
        @(negedge clk);
        send = 1'b0;
        check_bits("first word", 8'hc3, d1);
        check_bits("second word", 8'h81, d2);
        check_bits("framing", 8'h03, {6'h00, ok1, ok2});
        check_bits("start delay in range", 8'h01, {7'h00, (w1 >= 32 && w1 <= 100)});
        repeat (100) @(negedge clk);
        check_bits("line after transfer", 8'h00, {7'h00, tx_n});
    endtask

    // Host stalls: two commands held, the third dropped, then drained in order
    task automatic t_buffer();
        int o0, s0;
        o0 = n_overrun;
        s0 = n_strobe;
        cmd_q.delete();
        cmd_ready = 1'b0;
        send_pair(STATION, 7'h4a, 1'b0);
        send_pair(STATION, 7'h01, 1'b0);
        send_pair(STATION, 7'h7f, 1'b0);
        check_count("strobes while stalled", s0, n_strobe);
        check_count("overruns", o0 + 1, n_overrun);
        // Enable low freezes the buffer, so a ready host still sees no strobe
        clk_en = 1'b0;
        cmd_ready = 1'b1;
        repeat (10) @(negedge clk);
        check_count("strobes while frozen", s0, n_strobe);
        clk_en = 1'b1;
        repeat (10) @(negedge clk);
        check_count("strobes after drain", s0 + 2, n_strobe);
        check_bits("first held command", 8'h4a, pop_cmd());
        check_bits("second held command", 8'h01, pop_cmd());
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        clk_en = 1'b1;
        rst_n = 1'b0;
        send = 1'b0;
        cmd_ready = 1'b1;
        station = STATION;
        byte1 = 8'h00;
        byte2 = 8'h00;
        // Held 28 cycles, not 20: shorter would break the 700 ns minimum
        repeat (28) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        check_count("match pulses after reset", 0, n_match);
        t_match_command();
        t_transmit();
        t_bad_parity();
        t_mismatch();
        t_buffer();
        tally_and_finish();
    end

    // About 20000 cycles expected; twice that is allowed
    initial begin
        #1000000;
        n_mismatch++;
        $display("unexpected watchdog: expected end of tests, seen timeout");
        tally_and_finish();
    end
endmodule // asr_top_test
